// ### hw/afh_device.sv
// filter device end: processor port registers, result queue and learning outputs
`timescale 1ns/1ps
`default_nettype none
`include "afh_defines.svh"
// How it works
// - unicast da hit gives port, otherwise floods others
// - sa miss adds, hit updates port
// - every table write carries 8-bit stamp
// - purge starts from pin or command
// - host picks routines via command register
// - host configures cam via two registers
// - 16-bit data, 8-bit address port
// - system select reaches 23 shared registers
// - own select reaches chip, port registers
// - write low stores, high drives data
// - ready asserts after write or read done
// - shared ready: master system, selected otherwise
// - interrupt only for enabled events
// - software rereads result status per result
// - result data read pops next result
// - result interrupt holds until queue empty
// - result port users disable result interrupt
// - full interrupt clears after status read, removal
// - type: broadcast 00, multicast 01, unicast 10
// - each result delivered by one path only, unless a result data read and a port pop fall in one cycle
module afh_device (
    input wire logic clk_i,
    input wire logic nrst_i,
    afh_if.device port,
    input wire logic is_master_i,
    input wire logic pkt_valid_i,
    input wire logic [5:0] pkt_src_port_i,
    input wire afh_pkg::afh_pkt_type_t pkt_type_i,
    input wire logic da_hit_i,
    input wire logic [5:0] da_port_i,
    input wire logic sa_hit_i,
    input wire logic cam_full_i,
    input wire logic cam_removed_i,
    input wire logic rp_sel_i,
    input wire logic rp_next_i,
    output logic rp_valid_o,
    output logic [15:0] rp_data_o,
    output logic learn_valid_o,
    output logic learn_add_o,
    output logic [5:0] learn_port_o,
    output logic [7:0] learn_stamp_o,
    output logic purge_start_o,
    output logic sys_cmd_valid_o,
    output logic [15:0] sys_cmd_o,
    output logic cam_cmd_valid_o,
    output logic [15:0] cam_ctrl_o,
    output logic [15:0] cam_dw0_o
);
    afh_pkg::afh_dev_state_t state_q, state_d;
    logic master_q;
    logic [15:0] target_q, rdata_q, port_regs_q [0:15], chip_role_q, stamp_q;
    logic [15:0] qmem_q [0:`AFH_QDEPTH-1];
    logic [`AFH_QAW-1:0] wptr_q, rptr_q;
    logic [`AFH_QAW:0] count_q;
    logic full_flag_q, full_seen_q, irq_n_q, purge_pin_q;
    logic rd_q;

    wire sys_sel = ~port.system_chip_select_n;
    wire dev_sel = ~port.device_chip_select_n;
    wire any_sel = sys_sel | dev_sel;
    wire take = (state_q == afh_pkg::AFH_DEV_IDLE) & any_sel;
    wire wr = take & ~port.write_n;
    wire rd = take & port.write_n;
    wire [7:0] a = port.addr;
    wire sys_ok = sys_sel & (a < `AFH_SYS_NREGS);
    wire chip_ok = dev_sel & (a < `AFH_CHIP_NREGS);
    wire port_ok = dev_sel & (a >= `AFH_PORT_BASE) & (a < `AFH_PORT_BASE + `AFH_PORT_NREGS);
    wire [3:0] pidx = a[3:0];
    // side effects of shared system reads only on the master
    wire sys_rd_fx = rd & sys_ok & master_q;
    wire result_data_reg_rd = sys_rd_fx & (a == `AFH_RES_DATA);
    wire system_status_reg_rd = sys_rd_fx & (a == `AFH_SYS_STATUS);
    wire cmd_wr = wr & sys_ok & (a == `AFH_SYS_CMD);
    wire cam_dw0_wr = wr & sys_ok & (a == `AFH_CAM_DW0);
    wire q_empty = (count_q == '0);
    wire q_full = (count_q == (`AFH_QAW+1)'(`AFH_QDEPTH));
    wire port_pop = rp_sel_i & rp_next_i & ~q_empty;
    wire pop = (result_data_reg_rd & ~q_empty) | port_pop;
    wire push = pkt_valid_i & ~q_full;
    wire [15:0] head = qmem_q[rptr_q];
    wire is_ucast = (pkt_type_i == afh_pkg::AFH_UCAST);
    wire match = is_ucast & da_hit_i;
    wire [5:0] dest = match ? da_port_i : ~pkt_src_port_i;
    wire [15:0] result = {pkt_src_port_i, pkt_type_i, match, dest, match & (da_port_i == pkt_src_port_i)};
    wire [15:0] result_status_reg = {11'h000, count_q, ~q_empty};
    wire [15:0] system_status_reg = {15'h0000, full_flag_q};
    wire [15:0] sys_rd = (a == `AFH_SYS_CMD) ? sys_cmd_o :
                         (a == `AFH_SYS_TARGET) ? target_q :
                         (a == `AFH_SYS_STATUS) ? system_status_reg :
                         (a == `AFH_RES_STATUS) ? result_status_reg :
                         (a == `AFH_RES_DATA) ? (q_empty ? 16'h0000 : head) :
                         (a == `AFH_CAM_CTRL) ? cam_ctrl_o :
                         (a == `AFH_CAM_DW0) ? cam_dw0_o :
                         (a == `AFH_STAMP) ? stamp_q : 16'h0000;
    wire [15:0] rd_mux = sys_ok ? sys_rd :
                         (chip_ok & (a == `AFH_CHIP_ROLE)) ? chip_role_q :
                         port_ok ? port_regs_q[pidx] : 16'h0000;
    wire res_irq = target_q[`AFH_TGT_RESULT] & port_regs_q[0][`AFH_TGT_RESULT] & ~q_empty;
    wire full_irq = target_q[`AFH_TGT_FULL] & full_flag_q;
    wire is_ready = (state_q == afh_pkg::AFH_DEV_READY);
    wire may_drive = dev_sel | (sys_sel & master_q);
    wire purge_pin_rise = ~port.purge_n & ~purge_pin_q;

    always_comb begin
        case (state_q)
            afh_pkg::AFH_DEV_IDLE: state_d = any_sel ? afh_pkg::AFH_DEV_READY : afh_pkg::AFH_DEV_IDLE;
            afh_pkg::AFH_DEV_READY: state_d = any_sel ? afh_pkg::AFH_DEV_READY : afh_pkg::AFH_DEV_IDLE;
            default: state_d = afh_pkg::AFH_DEV_IDLE;
        endcase
    end

    assign port.dev_ready = 1'b1;
    assign port.dev_ready_oe = is_ready & may_drive;
    assign port.dev_data = rdata_q;
    assign port.dev_data_oe = is_ready & rd_q & may_drive;
    assign port.host_irq_n = irq_n_q;
    assign rp_valid_o = ~q_empty;
    assign rp_data_o = head;
    assign learn_stamp_o = stamp_q[7:0];

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_q <= afh_pkg::AFH_DEV_IDLE;
            rd_q <= 1'b0;
            rdata_q <= `AFH_RST16;
        end else begin
            state_q <= state_d;
            if (take) begin
                rd_q <= port.write_n;
                rdata_q <= rd_mux;
            end
        end
    end

    // strap resampled in every idle, unselected cycle after reset release, unless the last access was a read
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            master_q <= 1'b0;
        end else if (!rd_q && state_q == afh_pkg::AFH_DEV_IDLE && !any_sel) begin
            master_q <= is_master_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            target_q <= `AFH_RST16;
            sys_cmd_o <= `AFH_RST16;
            cam_ctrl_o <= `AFH_RST16;
            cam_dw0_o <= `AFH_RST16;
            stamp_q <= `AFH_RST16;
            chip_role_q <= `AFH_RST16;
        end else if (wr) begin
            if (sys_ok && a == `AFH_SYS_TARGET) target_q <= port.data;
            if (cmd_wr) sys_cmd_o <= port.data;
            if (sys_ok && a == `AFH_CAM_CTRL) cam_ctrl_o <= port.data;
            if (cam_dw0_wr) cam_dw0_o <= port.data;
            if (sys_ok && a == `AFH_STAMP) stamp_q <= {8'h00, port.data[7:0]};
            if (chip_ok && a == `AFH_CHIP_ROLE) chip_role_q <= port.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 16; i++) port_regs_q[i] <= `AFH_RST16;
        end else if (wr && port_ok) begin
            port_regs_q[pidx] <= port.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sys_cmd_valid_o <= 1'b0;
            cam_cmd_valid_o <= 1'b0;
            purge_start_o <= 1'b0;
            purge_pin_q <= 1'b0;
        end else begin
            sys_cmd_valid_o <= cmd_wr;
            cam_cmd_valid_o <= cam_dw0_wr;
            purge_pin_q <= ~port.purge_n;
            purge_start_o <= purge_pin_rise | (cmd_wr && port.data == `AFH_CMD_PURGE);
        end
    end

    // learning: add on miss, update on hit, always with current stamp
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            learn_valid_o <= 1'b0;
            learn_add_o <= 1'b0;
            learn_port_o <= 6'h00;
        end else begin
            learn_valid_o <= pkt_valid_i;
            learn_add_o <= ~sa_hit_i;
            learn_port_o <= pkt_src_port_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                qmem_q[wptr_q] <= result;
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) rptr_q <= rptr_q + 1'b1;
            count_q <= count_q + (`AFH_QAW+1)'(push) - (`AFH_QAW+1)'(pop);
        end
    end

    // full flag: set wins over clear
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            full_flag_q <= 1'b0;
            full_seen_q <= 1'b0;
            irq_n_q <= 1'b1;
        end else begin
            if (cam_full_i) begin
                full_flag_q <= 1'b1;
                full_seen_q <= full_seen_q | system_status_reg_rd;
            end else if (full_flag_q && full_seen_q && cam_removed_i) begin
                full_flag_q <= 1'b0;
                full_seen_q <= 1'b0;
            end else if (system_status_reg_rd && full_flag_q) begin
                full_seen_q <= 1'b1;
            end
            irq_n_q <= ~(res_irq | full_irq);
        end
    end
endmodule : afh_device
`default_nettype wire

// ### hw/afh_host.sv
// host end: Avalon-MM slave turned into processor port cycles
`timescale 1ns/1ps
`default_nettype none
`include "afh_defines.svh"
module afh_host (
    input wire logic clk_i,
    input wire logic nrst_i,
    afh_if.host port,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [15:0] avs_writedata,
    output logic [15:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq_o
);
    afh_pkg::afh_hst_state_t state_q, state_d;
    logic [15:0] rdata_q;
    logic purge_q;
    wire req = avs_read | avs_write;
    wire local_acc = avs_address[`AFH_AVS_LOCAL];
    wire remote = req & ~local_acc;
    wire in_access = (state_q == afh_pkg::AFH_HST_ACCESS);
    wire done = (state_q == afh_pkg::AFH_HST_DONE);
    wire sys_acc = avs_address[`AFH_AVS_SYS];

    always_comb begin
        case (state_q)
            afh_pkg::AFH_HST_IDLE: state_d = remote ? afh_pkg::AFH_HST_ACCESS : afh_pkg::AFH_HST_IDLE;
            afh_pkg::AFH_HST_ACCESS: state_d = port.host_transfer_ready ? afh_pkg::AFH_HST_DONE : afh_pkg::AFH_HST_ACCESS;
            afh_pkg::AFH_HST_DONE: state_d = afh_pkg::AFH_HST_IDLE;
            default: state_d = afh_pkg::AFH_HST_IDLE;
        endcase
    end

    assign port.addr = avs_address[7:0];
    assign port.write_n = ~avs_write;
    assign port.host_data = avs_writedata;
    assign port.host_data_oe = in_access & avs_write;
    assign port.system_chip_select_n = ~(in_access & sys_acc);
    assign port.device_chip_select_n = ~(in_access & ~sys_acc);
    assign port.purge_n = ~purge_q;
    assign avs_waitrequest = req & ~local_acc & ~done;
    assign avs_readdata = local_acc ? {14'h0000, irq_o, purge_q} : rdata_q;
    assign irq_o = ~port.host_irq_n;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_q <= afh_pkg::AFH_HST_IDLE;
            rdata_q <= `AFH_RST16;
            purge_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (in_access && port.host_transfer_ready) rdata_q <= port.data;
            if (avs_write && local_acc) purge_q <= avs_writedata[`AFH_LOC_PURGE];
        end
    end
endmodule : afh_host
`default_nettype wire

// ### pkg/afh_defines.svh
// register offsets, field positions, reset values and sizes of the filter host port
`ifndef AFH_DEFINES_SVH
`define AFH_DEFINES_SVH
`define AFH_AW 8
`define AFH_DW 16
`define AFH_SYS_CMD 8'h00
`define AFH_SYS_TARGET 8'h01
`define AFH_SYS_STATUS 8'h02
`define AFH_RES_STATUS 8'h03
`define AFH_RES_DATA 8'h04
`define AFH_CAM_CTRL 8'h05
`define AFH_CAM_DW0 8'h06
`define AFH_STAMP 8'h07
`define AFH_SYS_NREGS 8'h17
`define AFH_CHIP_ROLE 8'h00
`define AFH_CHIP_NREGS 8'h04
`define AFH_PORT_BASE 8'h10
`define AFH_PORT_TARGET 8'h10
`define AFH_PORT_NREGS 8'h10
`define AFH_CMD_PURGE 16'h0001
`define AFH_TGT_RESULT 0
`define AFH_TGT_FULL 1
`define AFH_STAT_FULL 0
`define AFH_PT_BCAST 2'h0
`define AFH_PT_MCAST 2'h1
`define AFH_PT_UCAST 2'h2
`define AFH_QDEPTH 8
`define AFH_QAW 3
`define AFH_RST16 16'h0000
`define AFH_RST8 8'h00
`define AFH_AVS_LOCAL 9
`define AFH_AVS_SYS 8
`define AFH_LOC_PURGE 0
`endif

// ### pkg/afh_if.sv
// processor port pins between host and filter device
`timescale 1ns/1ps
`default_nettype none
interface afh_if;
    logic [7:0] addr;
    logic [15:0] host_data;
    logic host_data_oe;
    logic [15:0] dev_data;
    logic dev_data_oe;
    logic [15:0] data;
    logic system_chip_select_n;
    logic device_chip_select_n;
    logic write_n;
    logic dev_ready;
    logic dev_ready_oe;
    logic host_transfer_ready;
    logic host_irq_n;
    logic purge_n;
    // resolved wire levels; undriven ready is pulled low, undriven data reads as zero
    assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 16'h0000);
    assign host_transfer_ready = dev_ready_oe & dev_ready;
    modport device (
        input addr, data, system_chip_select_n, device_chip_select_n, write_n, purge_n,
        output dev_data, dev_data_oe, dev_ready, dev_ready_oe, host_irq_n
    );
    modport host (
        input data, host_transfer_ready, host_irq_n,
        output addr, host_data, host_data_oe, system_chip_select_n, device_chip_select_n,
        write_n, purge_n
    );
endinterface : afh_if
`default_nettype wire

// ### pkg/afh_pkg.sv
// types shared by both ends of the filter host port
package afh_pkg;
    typedef enum logic [1:0] {
        AFH_DEV_IDLE = 2'b01,
        AFH_DEV_READY = 2'b10
    } afh_dev_state_t;
    typedef enum logic [2:0] {
        AFH_HST_IDLE = 3'b001,
        AFH_HST_ACCESS = 3'b010,
        AFH_HST_DONE = 3'b100
    } afh_hst_state_t;
    typedef enum logic [1:0] {
        AFH_BCAST = 2'h0,
        AFH_MCAST = 2'h1,
        AFH_UCAST = 2'h2
    } afh_pkt_type_t;
endpackage : afh_pkg

// ### sim/address_filter_host_port_test.sv
// self-checking bench joining host and device ends of the filter port
`timescale 1ns/1ps
`default_nettype none
module address_filter_host_port_test;
    logic clk_i, nrst_i, is_master_i, pkt_valid_i, da_hit_i, sa_hit_i, cam_full_i, cam_removed_i;
    logic rp_sel_i, rp_next_i, rp_valid_o, learn_valid_o, learn_add_o, purge_start_o;
    logic sys_cmd_valid_o, cam_cmd_valid_o, avs_read, avs_write, avs_waitrequest, irq_o;
    logic [5:0] pkt_src_port_i, da_port_i, learn_port_o;
    logic [7:0] learn_stamp_o, st;
    logic [9:0] avs_address;
    logic [15:0] rp_data_o, sys_cmd_o, cam_ctrl_o, cam_dw0_o, avs_writedata, avs_readdata, rd, v, w;
    afh_pkg::afh_pkt_type_t pkt_type_i;
    int fails, cmp_count, purges, cmds, ccmds, k, n;
    logic [15:0] expq[$];
    afh_if u_afh_if ();
    afh_device u_afh_device (.clk_i(clk_i), .nrst_i(nrst_i), .port(u_afh_if), .is_master_i(is_master_i),
        .pkt_valid_i(pkt_valid_i), .pkt_src_port_i(pkt_src_port_i), .pkt_type_i(pkt_type_i), .da_hit_i(da_hit_i),
        .da_port_i(da_port_i), .sa_hit_i(sa_hit_i), .cam_full_i(cam_full_i), .cam_removed_i(cam_removed_i),
        .rp_sel_i(rp_sel_i), .rp_next_i(rp_next_i), .rp_valid_o(rp_valid_o), .rp_data_o(rp_data_o),
        .learn_valid_o(learn_valid_o), .learn_add_o(learn_add_o), .learn_port_o(learn_port_o),
        .learn_stamp_o(learn_stamp_o), .purge_start_o(purge_start_o), .sys_cmd_valid_o(sys_cmd_valid_o),
        .sys_cmd_o(sys_cmd_o), .cam_cmd_valid_o(cam_cmd_valid_o), .cam_ctrl_o(cam_ctrl_o), .cam_dw0_o(cam_dw0_o));
    afh_host u_afh_host (.clk_i(clk_i), .nrst_i(nrst_i), .port(u_afh_if), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq_o(irq_o));
    afh_props u_afh_props (.clk_i(clk_i), .nrst_i(nrst_i), .addr(u_afh_if.addr), .write_n(u_afh_if.write_n),
        .system_chip_select_n(u_afh_if.system_chip_select_n), .device_chip_select_n(u_afh_if.device_chip_select_n),
        .host_data_oe(u_afh_if.host_data_oe), .dev_data_oe(u_afh_if.dev_data_oe), .dev_ready_oe(u_afh_if.dev_ready_oe));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        if (fails == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic av(input logic wr, input logic [9:0] a, input logic [15:0] wd);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_i);
    endtask : av
    task automatic irq_is(input logic e);
        @(negedge clk_i);
        check({14'h0, irq_o, u_afh_if.host_irq_n}, {14'h0, !e, e});
        @(posedge clk_i);
    endtask : irq_is
    task automatic pkt(input afh_pkg::afh_pkt_type_t t, input logic h);
        logic [5:0] s, p;
        logic sh, m;
        s = 6'($urandom_range(0, 3));
        p = 6'($urandom_range(0, 3));
        sh = 1'($urandom);
        m = h && t == afh_pkg::AFH_UCAST;
        pkt_src_port_i <= s;
        da_port_i <= p;
        sa_hit_i <= sh;
        da_hit_i <= h;
        pkt_type_i <= t;
        pkt_valid_i <= 1'b1;
        @(posedge clk_i);
        pkt_valid_i <= 1'b0;
        @(negedge clk_i);
        check({learn_valid_o, learn_add_o, learn_port_o, learn_stamp_o}, {1'b1, !sh, s, st});
        expq.push_back({s, t, m, m ? p : ~s, m && p == s});
        @(posedge clk_i);
    endtask : pkt
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
    always @(posedge clk_i) begin
        purges += int'(purge_start_o);
        cmds += int'(sys_cmd_valid_o);
        ccmds += int'(cam_cmd_valid_o);
    end
    initial begin
        void'($urandom(51044));
        {nrst_i, pkt_valid_i, da_hit_i, sa_hit_i, cam_full_i, cam_removed_i, rp_sel_i, rp_next_i} = 8'h00;
        {avs_read, avs_write, avs_address, avs_writedata, pkt_src_port_i, da_port_i} = 40'h0;
        pkt_type_i = afh_pkg::AFH_BCAST;
        is_master_i = 1'b1;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        st = 8'($urandom);
        av(1, 10'h107, {8'h00, st});
        av(0, 10'h107, 16'h0);
        check({8'h00, rd[7:0]}, {8'h00, st});
        v = 16'($urandom);
        w = 16'($urandom);
        av(1, 10'h105, v);
        av(1, 10'h106, w);
        check(cam_ctrl_o, v);
        check(cam_dw0_o, w);
        check(16'(ccmds), 16'h1);
        k = cmds;
        v = 16'($urandom) | 16'h0002;
        av(1, 10'h100, v);
        check(sys_cmd_o, v);
        check(16'(cmds - k), 16'h1);
        k = purges;
        av(1, 10'h100, 16'h0001);
        check(16'(purges - k), 16'h1);
        k = purges;
        av(1, 10'h200, 16'h1);
        av(1, 10'h200, 16'h0);
        check(16'(purges - k), 16'h1);
        av(1, 10'h008, 16'hffff);
        av(0, 10'h008, 16'h0);
        check(rd, 16'h0);
        av(1, 10'h101, 16'h0003);
        av(1, 10'h010, 16'h0001);
        n = $urandom_range(3, 6);
        for (k = 0; k < n; k++) pkt(afh_pkg::afh_pkt_type_t'(k % 3), 1'($urandom));
        irq_is(1'b0);
        av(0, 10'h103, 16'h0);
        check({11'h0, rd[4:0]}, {11'h0, 4'(n), 1'b1});
        for (k = 0; k < n; k++) begin
            irq_is(1'b0);
            av(0, 10'h104, 16'h0);
            check(rd, expq[k]);
        end
        irq_is(1'b1);
        av(1, 10'h101, 16'h0002);
        pkt(afh_pkg::AFH_UCAST, 1'b1);
        repeat (2) @(posedge clk_i);
        irq_is(1'b1);
        check({15'h0, rp_valid_o}, 16'h1);
        check(rp_data_o, expq[n]);
        rp_sel_i <= 1'b1;
        rp_next_i <= 1'b1;
        @(posedge clk_i);
        rp_sel_i <= 1'b0;
        rp_next_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        av(0, 10'h103, 16'h0);
        check({11'h0, rd[4:0]}, 16'h0);
        cam_full_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        irq_is(1'b0);
        cam_full_i <= 1'b0;
        cam_removed_i <= 1'b1;
        @(posedge clk_i);
        cam_removed_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        irq_is(1'b0);
        av(0, 10'h102, 16'h0);
        check({15'h0, rd[0]}, 16'h1);
        cam_removed_i <= 1'b1;
        @(posedge clk_i);
        cam_removed_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        irq_is(1'b1);
        nrst_i <= 1'b0;
        is_master_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        check(cam_dw0_o, 16'h0);
        irq_is(1'b1);
        v = 16'($urandom);
        av(1, 10'h000, v);
        av(0, 10'h000, 16'h0);
        check(rd, v);
        report_and_stop();
    end
endmodule : address_filter_host_port_test
`default_nettype wire

// ### sim/afh_props.sv
// concurrent checks on the processor port pins between host and device
`timescale 1ns/1ps
`default_nettype none
module afh_props (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr,
    input wire logic write_n,
    input wire logic system_chip_select_n,
    input wire logic device_chip_select_n,
    input wire logic host_data_oe,
    input wire logic dev_data_oe,
    input wire logic dev_ready_oe
);
    wire logic sel_lo;
    assign sel_lo = !system_chip_select_n || !device_chip_select_n;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence ready_seen_s; ##[1:3] dev_ready_oe; endsequence
    sequence release_s; ##[1:6] !sel_lo; endsequence
    one_select_a: assert property (!(!system_chip_select_n && !device_chip_select_n))
        else $error("both selects low");
    ready_answer_a: assert property ($rose(sel_lo) |-> ready_seen_s)
        else $error("no ready after select");
    ready_hold_a: assert property (dev_ready_oe && sel_lo |=> dev_ready_oe || !sel_lo)
        else $error("ready dropped early");
    access_end_a: assert property ($rose(sel_lo) |-> release_s)
        else $error("access never ends");
    idle_gap_a: assert property ($fell(sel_lo) |=> !sel_lo)
        else $error("no idle cycle between accesses");
    float_idle_a: assert property (!sel_lo && $past(!sel_lo) |-> !dev_data_oe && !dev_ready_oe)
        else $error("device drives while unselected");
    read_drive_a: assert property (dev_data_oe && sel_lo |-> write_n)
        else $error("device drives on a write");
    no_contend_a: assert property (!(host_data_oe && dev_data_oe))
        else $error("data bus contention");
    req_stable_a: assert property (sel_lo && $past(sel_lo) |-> $stable(addr) && $stable(write_n))
        else $error("request changed mid access");
endmodule : afh_props
`default_nettype wire
